// File: core/txhfo_consts.vh
// constants for the transmit highway frame offset block
`ifndef TXHFO_CONSTS_VH
`define TXHFO_CONSTS_VH

// register map: one 16-byte group per highway above the base
`define TXHFO_HWY_BASE      4'h1
`define TXHFO_OFS_BIT_CFG   2'h0
`define TXHFO_OFS_SLOT_CFG  2'h1
`define TXHFO_OFS_RATE_CFG  2'h2

// field positions
`define TXHFO_WBIT_MSB      6
`define TXHFO_WBIT_LSB      4
`define TXHFO_QBIT_MSB      3
`define TXHFO_QBIT_LSB      2
`define TXHFO_SLOT_MSB      6
`define TXHFO_SLOT_LSB      0
`define TXHFO_RATE_MSB      1
`define TXHFO_RATE_LSB      0

// reset values
`define TXHFO_RST_WBIT      3'h0
`define TXHFO_RST_QBIT      2'h0
`define TXHFO_RST_SLOT      7'h00
`define TXHFO_RST_RATE      2'h0

// rate codes
`define TXHFO_RATE_2M       2'h0
`define TXHFO_RATE_4M       2'h1
`define TXHFO_RATE_8M       2'h2
`define TXHFO_RATE_IDLE     2'h3

// quarter-bit ticks per bit at the fastest rate
`define TXHFO_QTR_PER_BIT   5'h04

`endif

// File: core/txhfo_hwy_timer.v
// per-highway frame start and bit strobe timer
`timescale 1ns/1ps
`include "txhfo_consts.vh"

module txhfo_hwy_timer (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // common timing reference
    input  wire        qbit_tick,
    input  wire        frame_sync,
    // configuration of this highway
    input  wire [2:0]  tx_whole_bit_shift,
    input  wire [1:0]  tx_quarter_bit_shift,
    input  wire [6:0]  tx_slot_shift,
    input  wire [1:0]  tx_line_rate_select,
    // transmit shifter timing
    output reg         frame_start_ff,
    output reg         bit_strobe_ff,
    output reg         active_ff
);

    reg  [13:0] count_ff;
    reg         arm_ff;
    reg         run_ff;
    reg  [4:0]  sub_ff;
    wire        idle;
    wire [1:0]  slow_shift;
    wire [11:0] qtr_total;
    wire [13:0] tick_total;
    wire [4:0]  ticks_per_bit;
    wire        start_now;
    wire        start_late;
    wire        start;

    assign idle = (tx_line_rate_select == `TXHFO_RATE_IDLE);
    // ticks per quarter bit: 4 at 2.048, 2 at 4.096, 1 at 8.192
    assign slow_shift = idle ? 2'h0 : (2'h2 - tx_line_rate_select);
    // slot*32 + bit*4 + quarter, all in quarter bits
    assign qtr_total = {tx_slot_shift, tx_whole_bit_shift,
                        tx_quarter_bit_shift};
    assign tick_total = {2'h0, qtr_total} << slow_shift;
    assign ticks_per_bit = `TXHFO_QTR_PER_BIT << slow_shift;
    assign start_now = frame_sync & ~idle & (tick_total == 14'h0000);
    assign start_late = arm_ff & qbit_tick & ~frame_sync & ~idle
                        & (count_ff == 14'h0001);
    assign start = start_now | start_late;

    always @(posedge ref_clk) begin
        if (reset) begin
            count_ff       <= 14'h0000;
            arm_ff         <= 1'b0;
            run_ff         <= 1'b0;
            sub_ff         <= 5'h00;
            frame_start_ff <= 1'b0;
            bit_strobe_ff  <= 1'b0;
            active_ff      <= 1'b0;
        end else begin
            active_ff      <= ~idle;
            frame_start_ff <= start;
            bit_strobe_ff  <= start | (run_ff & ~idle & qbit_tick
                              & (sub_ff == ticks_per_bit - 5'h01));
            if (idle) begin
                arm_ff <= 1'b0;
                run_ff <= 1'b0;
            end else if (frame_sync) begin
                count_ff <= tick_total;
                arm_ff   <= (tick_total != 14'h0000);
                if (start_now) begin
                    run_ff <= 1'b1;
                end
            end else if (start_late) begin
                arm_ff <= 1'b0;
                run_ff <= 1'b1;
            end else if (qbit_tick && arm_ff) begin
                count_ff <= count_ff - 14'h0001;
            end
            // bit grid keeps stepping on the frame sync tick too
            if (start) begin
                sub_ff <= 5'h00;
            end else if (run_ff && qbit_tick) begin
                if (sub_ff >= ticks_per_bit - 5'h01) begin
                    sub_ff <= 5'h00;
                end else begin
                    sub_ff <= sub_ff + 5'h01;
                end
            end
        end
    end

endmodule

// File: core/txhfo_frame_offset.v
// transmit highway frame offset block with apb register access
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "txhfo_consts.vh"

module txhfo_frame_offset #(
    parameter NUM_HWY = 32
) (
    // clock and reset
    input  wire               ref_clk,
    input  wire               reset,
    // apb slave
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [15:0]        paddr,
    input  wire [31:0]        pwdata,
    output wire               pready,
    output reg  [31:0]        prdata,
    output reg                pslverr,
    // common highway timing reference
    input  wire               qbit_tick,
    input  wire               frame_sync,
    // per-highway transmit timing
    output wire [NUM_HWY-1:0] tx_frame_start,
    output wire [NUM_HWY-1:0] tx_bit_strobe,
    output wire [NUM_HWY-1:0] tx_active
);

    localparam KIND_BIT  = `TXHFO_OFS_BIT_CFG;
    localparam KIND_SLOT = `TXHFO_OFS_SLOT_CFG;
    localparam KIND_RATE = `TXHFO_OFS_RATE_CFG;
    localparam KIND_NONE = 2'h3;

    // 0 for a mapped aligned word, with kind and highway index
    function [10:0] decode;
        input [15:0] addr;
        reg   [1:0]  kind;
        begin
            kind = addr[3:2];
            if (addr[15:12] != `TXHFO_HWY_BASE || addr[1:0] != 2'h0
                || kind == KIND_NONE
                || {24'h00_0000, addr[11:4]} >= NUM_HWY) begin
                decode = {1'b1, KIND_NONE, 8'h00};
            end else begin
                decode = {1'b0, kind, addr[11:4]};
            end
        end
    endfunction

    wire [10:0] dec;
    wire        dec_bad;
    wire [1:0]  dec_kind;
    wire [7:0]  dec_idx;
    wire        setup;
    wire        wr_go;

    assign dec      = decode(paddr);
    assign dec_bad  = dec[10];
    assign dec_kind = dec[9:8];
    assign dec_idx  = dec[7:0];
    assign setup    = psel & ~penable;
    assign wr_go    = psel & penable & pwrite & ~dec_bad;
    assign pready   = 1'b1;

    wire [31:0] nxt_prdata;
    // read words of all highways, or-ed along a chain
    wire [31:0] rd_chain [0:NUM_HWY];

    assign rd_chain[0] = 32'h0000_0000;

    genvar g;
    generate
        for (g = 0; g < NUM_HWY; g = g + 1) begin : g_hwy
            // each highway keeps its own offsets
            reg  [2:0]  wbit_ff;
            reg  [1:0]  qbit_ff;
            reg  [6:0]  slot_ff;
            reg  [1:0]  rate_ff;
            reg  [31:0] rd_word;
            wire        sel;
            wire        hit;

            assign sel = ~dec_bad && ({24'h00_0000, dec_idx} == g);
            assign hit = wr_go && sel;

            always @(posedge ref_clk) begin
                if (reset) begin
                    wbit_ff <= `TXHFO_RST_WBIT;
                    qbit_ff <= `TXHFO_RST_QBIT;
                    slot_ff <= `TXHFO_RST_SLOT;
                    rate_ff <= `TXHFO_RST_RATE;
                end else if (hit) begin
                    case (dec_kind)
                        KIND_BIT: begin
                            // low two bits are not stored
                            wbit_ff <= pwdata[`TXHFO_WBIT_MSB:
                                              `TXHFO_WBIT_LSB];
                            qbit_ff <= pwdata[`TXHFO_QBIT_MSB:
                                              `TXHFO_QBIT_LSB];
                        end
                        KIND_SLOT: begin
                            slot_ff <= pwdata[`TXHFO_SLOT_MSB:
                                              `TXHFO_SLOT_LSB];
                        end
                        KIND_RATE: begin
                            rate_ff <= pwdata[`TXHFO_RATE_MSB:
                                              `TXHFO_RATE_LSB];
                        end
                        default: begin
                            rate_ff <= rate_ff;
                        end
                    endcase
                end
            end

            // reserved bits stay zero in every read word
            always @* begin
                rd_word = 32'h0000_0000;
                case (dec_kind)
                    KIND_BIT: begin
                        rd_word[`TXHFO_WBIT_MSB:`TXHFO_WBIT_LSB] =
                            wbit_ff;
                        rd_word[`TXHFO_QBIT_MSB:`TXHFO_QBIT_LSB] =
                            qbit_ff;
                    end
                    KIND_SLOT: begin
                        rd_word[`TXHFO_SLOT_MSB:`TXHFO_SLOT_LSB] =
                            slot_ff;
                    end
                    KIND_RATE: begin
                        rd_word[`TXHFO_RATE_MSB:`TXHFO_RATE_LSB] =
                            rate_ff;
                    end
                    default: begin
                        rd_word = 32'h0000_0000;
                    end
                endcase
            end

            assign rd_chain[g+1] = rd_chain[g]
                                   | (sel ? rd_word : 32'h0000_0000);

            txhfo_hwy_timer u_timer (
                .ref_clk              (ref_clk),
                .reset                (reset),
                .qbit_tick            (qbit_tick),
                .frame_sync           (frame_sync),
                .tx_whole_bit_shift   (wbit_ff),
                .tx_quarter_bit_shift (qbit_ff),
                .tx_slot_shift        (slot_ff),
                .tx_line_rate_select  (rate_ff),
                .frame_start_ff       (tx_frame_start[g]),
                .bit_strobe_ff        (tx_bit_strobe[g]),
                .active_ff            (tx_active[g])
            );
        end
    endgenerate

    // only the addressed highway adds a nonzero word
    assign nxt_prdata = rd_chain[NUM_HWY];

    // read data and error are captured in the setup cycle
    always @(posedge ref_clk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : nxt_prdata;
            pslverr <= dec_bad;
        end
    end

endmodule

// File: verification/txhfo_line_rx.sv
// highway receiver model that times frame start and bit spacing
`timescale 1ns/1ps
module txhfo_line_rx (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // timing seen on the line
    input  wire        frame_sync,
    input  wire        start,
    input  wire        strobe,
    // measured alignment
    output reg         done_ff,
    output reg  [15:0] lat_ff,
    output reg  [5:0]  per_ff
);
    reg [15:0] cnt_ff;
    reg        arm_ff;
    // lat: cycles from sync to start, per: start to next bit boundary
    always @(posedge ref_clk) begin
        done_ff <= 1'b0;
        cnt_ff <= cnt_ff + 16'h0001;
        if (reset) begin
            cnt_ff <= 16'h0000;
            arm_ff <= 1'b0;
        end else if (frame_sync) begin
            cnt_ff <= 16'h0001;
        end else if (start) begin
            lat_ff <= cnt_ff;
            cnt_ff <= 16'h0001;
            arm_ff <= 1'b1;
        end else if (strobe && arm_ff) begin
            per_ff <= cnt_ff[5:0];
            done_ff <= 1'b1;
            arm_ff <= 1'b0;
        end
    end
endmodule

// File: verification/txhfo_chk.sv
// port assertions for the transmit frame offset block
`timescale 1ns/1ps
module txhfo_chk #(
    parameter NUM_HWY = 32
) (
    // clock, reset and apb
    input wire               ref_clk,
    input wire               reset,
    input wire               psel,
    input wire               penable,
    input wire               pwrite,
    input wire [15:0]        paddr,
    input wire [31:0]        pwdata,
    input wire               pready,
    input wire [31:0]        prdata,
    input wire               pslverr,
    // highway timing
    input wire               qbit_tick,
    input wire               frame_sync,
    input wire [NUM_HWY-1:0] tx_frame_start,
    input wire [NUM_HWY-1:0] tx_bit_strobe,
    input wire [NUM_HWY-1:0] tx_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire setup = psel && !penable;
    wire hit = paddr[15:12] == 4'h1 && paddr[1:0] == 2'h0
        && paddr[3:2] != 2'h3 && paddr[11:4] < NUM_HWY;
    ready_high_a: assert property (pready) else $error("pready low");
    unmap_err_a: assert property (setup && !hit |=> pslverr)
        else $error("unmapped access without error");
    map_ok_a: assert property (setup && hit |=> !pslverr)
        else $error("mapped access flagged as error");
    wr_zero_a: assert property (setup && pwrite |=> prdata == 32'h0000_0000)
        else $error("write returned data");
    rsv_high_a: assert property (setup |=> prdata[31:7] == 25'h000_0000)
        else $error("reserved high bits set");
    rsv_low_a: assert property (setup && paddr[3:0] == 4'h0
        |=> prdata[1:0] == 2'h0) else $error("reserved low bits set");
    start_bit_a: assert property ((tx_frame_start & ~tx_bit_strobe) == '0)
        else $error("frame start without bit strobe");
    start_once_a: assert property (|tx_frame_start
        |=> (tx_frame_start & $past(tx_frame_start)) == '0)
        else $error("frame start longer than one cycle");
    idle_quiet_a: assert property (((tx_frame_start | tx_bit_strobe)
        & ~tx_active & ~$past(tx_active)) == '0) else $error("idle pulses");
    cover property (setup && !hit);
    cover property (|tx_frame_start);
    cover property ($fell(tx_active[0]));
endmodule

bind txhfo_frame_offset txhfo_chk #(.NUM_HWY(NUM_HWY)) u_chk (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .qbit_tick(qbit_tick),
    .frame_sync(frame_sync), .tx_frame_start(tx_frame_start),
    .tx_bit_strobe(tx_bit_strobe), .tx_active(tx_active));

// File: verification/tx_highway_frame_offset_tb.sv
// self-checking bench for the transmit frame offset block
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
    err_total++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tx_highway_frame_offset_tb;
    reg ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    reg qbit_tick = 0, frame_sync = 0;
    reg [15:0] paddr = 16'h0000;
    reg [31:0] pwdata = 32'h0000_0000, rnd = 32'h0000_005a;
    wire pready, pslverr;
    wire [31:0] prdata, lat;
    wire [1:0] fs, bs, done, act;
    wire [11:0] per;
    integer err_total = 0, total_checks = 0, cyc = 0, t, i, dq;
    reg [2:0] w;
    reg [1:0] q, r;
    reg [6:0] s;
    logic [32:0] rq[$], x;
    logic [21:0] fq0[$], fq1[$];
    logic [15:0] bad[4] = '{16'h2000, 16'h100c, 16'h1020, 16'h1001};
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) qbit_tick <= ~qbit_tick;
    txhfo_frame_offset #(.NUM_HWY(2)) dut (.ref_clk(ref_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .qbit_tick(qbit_tick), .frame_sync(frame_sync),
        .tx_frame_start(fs), .tx_bit_strobe(bs), .tx_active(act));
    txhfo_line_rx rx[1:0] (.ref_clk(ref_clk), .reset(reset),
        .frame_sync(frame_sync), .start(fs), .strobe(bs), .done_ff(done),
        .lat_ff(lat), .per_ff(per));
    function automatic [31:0] xs(input [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // e is the expected {pslverr, prdata} of the access phase
    task apb(input w1, input [15:0] a, input [31:0] d, input [32:0] e);
        @(posedge ref_clk);
        rq.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w1;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task end_of_test;
        err_total += rq.size() + fq0.size() + fq1.size();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            end_of_test();
        end
        if (psel && penable && pready) begin
            x = rq.pop_front();
            `CHK("apb", x, {pslverr, prdata})
        end
        if (done[0]) begin
            x = {11'h0, fq0.pop_front()};
            `CHK("hwy0", x, {11'h0, lat[15:0], per[5:0]})
        end
        if (done[1]) begin
            x = {11'h0, fq1.pop_front()};
            `CHK("hwy1", x, {11'h0, lat[31:16], per[11:6]})
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (bad[i]) apb(!i[0], bad[i], 32'hffff_ffff, {1'b1, 32'h0});
        for (i = 0; i < 6; i++)
            apb(0, 16'(16'h1000 + (i / 3) * 16 + (i % 3) * 4), 0, 33'h0);
        for (t = 0; t < 8; t++) begin
            rnd = xs(rnd);
            w = rnd[6:4];
            q = rnd[3:2];
            s = (t == 6) ? 7'h7f : {5'h00, rnd[9:8]};
            r = t[1:0];
            apb(1, 16'h1000, {24'h0, 1'b1, w, q, 2'b00}, 33'h0);
            apb(0, 16'h1000, 0, {26'h0, w, q, 2'b00});
            apb(1, 16'h1004, {24'h0, 1'b1, s}, 33'h0);
            apb(0, 16'h1004, 0, {26'h0, s});
            apb(1, 16'h1008, {30'h0, r}, 33'h0);
            apb(1, 16'h1010, {25'h0, t[2:0], 4'h0}, 33'h0);
            apb(1, 16'h1018, 32'h0000_0002, 33'h0);
            dq = s * 32 + w * 4 + q;
            if (r != 2'h3)
                fq0.push_back({16'(2 * (dq << (2 - r)) + 1), 6'(32 >> r)});
            fq1.push_back({16'(8 * t + 1), 6'd8});
            @(posedge ref_clk);
            while (qbit_tick) @(posedge ref_clk);
            frame_sync <= 1'b1;
            @(posedge ref_clk);
            frame_sync <= 1'b0;
            for (i = 0; i < 9000 && fq0.size() + fq1.size() > 0; i++)
                @(posedge ref_clk);
            `CHK("active0", (r != 2'h3), act[0])
            `CHK("active1", 1'b1, act[1])
        end
        end_of_test();
    end
endmodule
